// ===== adcss_chan_seq.v
// Channel order: first input of a run and the input after the current one
`include "adcss_map.vh"
`default_nettype none

module adcss_chan_seq (
  input  wire       ch_only,
  input  wire       rs1,
  input  wire [2:0] ch_sel,
  input  wire [1:0] scan,
  input  wire [2:0] cur_ch,
  input  wire [2:0] pi,
  input  wire [2:0] ni,
  input  wire       turn,
  output wire [2:0] prio_cnt,
  output reg  [2:0] first_ch,
  output reg  [2:0] next_ch,
  output reg  [2:0] next_pi,
  output reg  [2:0] next_ni,
  output reg        next_turn,
  output reg        last
);

  wire [2:0] grp_last;
  wire [2:0] pi_inc;

  assign prio_cnt = {1'b0, scan} + 3'h1;
  assign grp_last = {scan, 1'b1};
  assign pi_inc   = pi + 3'h1;

  // Turn low: the current input was a priority one, a non-priority follows
  always @* begin
    first_ch  = 3'h0;
    next_ch   = 3'h0;
    next_pi   = pi;
    next_ni   = ni;
    next_turn = turn;
    last      = 1'b0;
    if (ch_only) begin
      first_ch = ch_sel;
      next_ch  = ch_sel;
      last     = 1'b1;
    end else if (rs1) begin
      if (!turn) begin
        next_ch   = ni;
        next_turn = 1'b1;
      end else begin
        next_pi   = (pi_inc == prio_cnt) ? 3'h0 : pi_inc;
        next_ni   = (ni == 3'h7) ? prio_cnt : ni + 3'h1;
        next_ch   = next_pi;
        next_turn = 1'b0;
      end
    end else begin
      last    = (cur_ch == grp_last);
      next_ch = last ? 3'h0 : cur_ch + 3'h1;
    end
  end

endmodule
`default_nettype wire

// ===== adcss_clk_div.v
// Conversion clock divider: one-cycle tick every N base clock cycles
`include "adcss_map.vh"
`default_nettype none

module adcss_clk_div (
  input  wire       clk,
  input  wire       reset_n,
  input  wire       ce,
  input  wire       clear,
  input  wire [2:0] div_code,
  output reg        tick_q
);

  reg  [3:0] cnt_q;
  reg  [3:0] lim;

  // Divisor per code; unused codes fall back to the slowest rate
  always @* begin
    case (div_code)
      3'h0:    lim = `ADCSS_DIV_1;
      3'h1:    lim = `ADCSS_DIV_2;
      3'h2:    lim = `ADCSS_DIV_3;
      3'h3:    lim = `ADCSS_DIV_4;
      3'h4:    lim = `ADCSS_DIV_6;
      default: lim = `ADCSS_DIV_12;
    endcase
  end

  // Clear realigns the phase so the first tick after a start is a full period
  always @(posedge clk) begin
    if (!reset_n) begin
      cnt_q  <= 4'h0;
      tick_q <= 1'b0;
    end else if (ce) begin
      if (clear || cnt_q == lim - 4'h1) begin
        cnt_q  <= 4'h0;
        tick_q <= ~clear;
      end else begin
        cnt_q  <= cnt_q + 4'h1;
        tick_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== adcss_map.vh
// Register map, field positions and timing counts of the sweep sequencer
`ifndef ADCSS_MAP_VH
`define ADCSS_MAP_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define ADCSS_ADDR_MODE      10'h3D6
`define ADCSS_ADDR_SWEEP     10'h3D7
`define ADCSS_ADDR_RES_BASE  10'h3C0

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define ADCSS_B_CH_LO     0
`define ADCSS_B_MD_A      3
`define ADCSS_B_MD_B      4
`define ADCSS_B_START     6
`define ADCSS_B_CLOCK_DIV_SEL_0      7
`define ADCSS_B_SCAN_LO   0
`define ADCSS_B_MD_X      2
`define ADCSS_B_CLOCK_DIV_SEL_1      4
`define ADCSS_B_STBY      5
`define ADCSS_RST_MODE    8'h00
`define ADCSS_RST_SWEEP   8'h00

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define ADCSS_CONV_CYC    6'h28
`define ADCSS_GAP_CYC     6'h01
`define ADCSS_END_CYC     6'h02
`define ADCSS_DIV_1       4'h1
`define ADCSS_DIV_2       4'h2
`define ADCSS_DIV_3       4'h3
`define ADCSS_DIV_4       4'h4
`define ADCSS_DIV_6       4'h6
`define ADCSS_DIV_12      4'hC
`define ADCSS_SD_DIV_1    6'h01
`define ADCSS_SD_DIV_2    6'h02
`define ADCSS_SD_DIV_3    6'h03
`define ADCSS_SD_DIV_4    6'h03
`define ADCSS_SD_DIV_6    6'h04
`define ADCSS_SD_DIV_12   6'h07

`endif

// ===== adcss_seq.v
// Sweep sequencer of the eight-input converter: control registers and timing
//
// Added by the designer: the address-and-strobe port.
`include "adcss_map.vh"
`default_nettype none

module adcss_seq #(
  parameter RES_W  = 10,
  parameter ADDR_W = 10
) (
  input  wire              clk,
  input  wire              reset_n,
  input  wire              ce,
  input  wire [ADDR_W-1:0] addr,
  input  wire [7:0]        wr_data,
  input  wire              wr_stb,
  input  wire              rd_stb,
  output reg  [7:0]        rd_data_q,
  input  wire              clock_div_ext,
  input  wire [RES_W-1:0]  conv_data,
  output reg               analog_enable_q,
  output reg               sample_active_q,
  output reg  [2:0]        sample_ch_q,
  output reg               sweep_done_q
);

  // ----------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------
  localparam [4:0] S_IDLE  = 5'b00001;
  localparam [4:0] S_START = 5'b00010;
  localparam [4:0] S_CONV  = 5'b00100;
  localparam [4:0] S_GAP   = 5'b01000;
  localparam [4:0] S_END   = 5'b10000;

  // Full-width copies so fields can be sliced without dropping bits
  localparam [7:0] RST_MODE = `ADCSS_RST_MODE;
  localparam [9:0] RES_BASE = `ADCSS_ADDR_RES_BASE;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  reg  [2:0]         ch_sel_q;
  reg                md_a_q;
  reg                md_b_q;
  reg                md_x_q;
  reg                clock_div_sel_0_q;
  reg                clock_div_sel_1_q;
  reg  [1:0]         scan_q;
  reg                conversion_start_flag_q;
  reg  [4:0]         state_q;
  reg  [5:0]         cnt_q;
  reg  [2:0]         pi_q;
  reg  [2:0]         ni_q;
  reg                turn_q;
  reg  [RES_W-1:0]   smp_q;
  reg                res_we_q;
  reg  [8*RES_W-1:0] res_flat_q;
  reg  [5:0]         start_dummy;
  reg  [7:0]         rd_mux;

  wire               phi_tick;
  wire [2:0]         div_code;
  wire [2:0]         prio_cnt;
  wire [2:0]         first_ch;
  wire [2:0]         next_ch;
  wire [2:0]         next_pi;
  wire [2:0]         next_ni;
  wire               next_turn;
  wire               last;
  wire               wr_mode;
  wire               wr_sweep;
  wire               start_req;
  wire               stop_req;
  wire               auto_end;
  wire               rs1;
  wire               ch_only;
  wire               res_hit;
  wire [2:0]         rd_idx;
  wire [RES_W-1:0]   rd_res;
  wire [15:0]        rd_res_pad;

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  // Mode bits b:a = 00 one-shot, 01 repeat, 10 single sweep, 11 repeat sweep
  assign ch_only  = ~md_b_q;
  assign rs1      = md_b_q & md_a_q & md_x_q;
  // Extra bit is not looked at in single sweep; software keeps it clear
  assign auto_end = ~md_a_q;
  assign div_code = {clock_div_ext, clock_div_sel_1_q, clock_div_sel_0_q};

  assign wr_mode   = wr_stb && (addr == `ADCSS_ADDR_MODE);
  assign wr_sweep  = wr_stb && (addr == `ADCSS_ADDR_SWEEP);
  // The standby bit must already be set by an earlier write before a start counts
  assign start_req = wr_mode && wr_data[`ADCSS_B_START] && analog_enable_q
                     && (state_q == S_IDLE);
  assign stop_req  = (wr_mode && !wr_data[`ADCSS_B_START])
                     || (wr_sweep && !wr_data[`ADCSS_B_STBY]);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  adcss_clk_div u_div (
    .clk      (clk),
    .reset_n  (reset_n),
    .ce       (ce),
    .clear    (start_req),
    .div_code (div_code),
    .tick_q   (phi_tick)
  );

  adcss_chan_seq u_seq (
    .ch_only   (ch_only),
    .rs1       (rs1),
    .ch_sel    (ch_sel_q),
    .scan      (scan_q),
    .cur_ch    (sample_ch_q),
    .pi        (pi_q),
    .ni        (ni_q),
    .turn      (turn_q),
    .prio_cnt  (prio_cnt),
    .first_ch  (first_ch),
    .next_ch   (next_ch),
    .next_pi   (next_pi),
    .next_ni   (next_ni),
    .next_turn (next_turn),
    .last      (last)
  );

  // Start dummy in base cycles, the short end of each range
  always @* begin
    case (div_code)
      3'h0:    start_dummy = `ADCSS_SD_DIV_1;
      3'h1:    start_dummy = `ADCSS_SD_DIV_2;
      3'h2:    start_dummy = `ADCSS_SD_DIV_3;
      3'h3:    start_dummy = `ADCSS_SD_DIV_4;
      3'h4:    start_dummy = `ADCSS_SD_DIV_6;
      default: start_dummy = `ADCSS_SD_DIV_12;
    endcase
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // Writes are taken in any state while ce is high; one that clears start or standby mid-conversion ends the run
  always @(posedge clk) begin
    if (!reset_n) begin
      ch_sel_q        <= RST_MODE[2:0];
      md_a_q          <= 1'b0;
      md_b_q          <= 1'b0;
      clock_div_sel_0_q          <= 1'b0;
      scan_q          <= 2'h0;
      md_x_q          <= 1'b0;
      clock_div_sel_1_q          <= 1'b0;
      analog_enable_q <= 1'b0;
    end else if (ce) begin
      if (wr_mode) begin
        ch_sel_q <= wr_data[`ADCSS_B_CH_LO +: 3];
        md_a_q   <= wr_data[`ADCSS_B_MD_A];
        md_b_q   <= wr_data[`ADCSS_B_MD_B];
        clock_div_sel_0_q   <= wr_data[`ADCSS_B_CLOCK_DIV_SEL_0];
      end
      if (wr_sweep) begin
        scan_q          <= wr_data[`ADCSS_B_SCAN_LO +: 2];
        md_x_q          <= wr_data[`ADCSS_B_MD_X];
        clock_div_sel_1_q          <= wr_data[`ADCSS_B_CLOCK_DIV_SEL_1];
        analog_enable_q <= wr_data[`ADCSS_B_STBY];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  // Counters run in base cycles in START and END, in conversion ticks else
  always @(posedge clk) begin
    if (!reset_n) begin
      state_q         <= S_IDLE;
      cnt_q           <= 6'h00;
      conversion_start_flag_q          <= 1'b0;
      sample_active_q <= 1'b0;
      sample_ch_q     <= 3'h0;
      pi_q            <= 3'h0;
      ni_q            <= 3'h0;
      turn_q          <= 1'b0;
      smp_q           <= {RES_W{1'b0}};
      res_we_q        <= 1'b0;
      sweep_done_q    <= 1'b0;
    end else if (ce) begin
      res_we_q     <= 1'b0;
      sweep_done_q <= 1'b0;
      if (stop_req && state_q != S_IDLE) begin
        state_q         <= S_IDLE;
        conversion_start_flag_q          <= 1'b0;
        sample_active_q <= 1'b0;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (start_req) begin
              state_q <= S_START;
              cnt_q   <= start_dummy - 6'h01;
            end
          end
          S_START: begin
            if (cnt_q == 6'h00) begin
              state_q         <= S_CONV;
              conversion_start_flag_q          <= 1'b1;
              sample_active_q <= 1'b1;
              sample_ch_q     <= first_ch;
              pi_q            <= 3'h0;
              ni_q            <= prio_cnt;
              turn_q          <= 1'b0;
              cnt_q           <= `ADCSS_CONV_CYC - 6'h01;
            end else begin
              cnt_q <= cnt_q - 6'h01;
            end
          end
          S_CONV: begin
            if (phi_tick) begin
              if (cnt_q == 6'h00) begin
                smp_q           <= conv_data;
                res_we_q        <= 1'b1;
                sample_active_q <= 1'b0;
                if (last && auto_end) begin
                  state_q      <= S_END;
                  conversion_start_flag_q       <= 1'b0;
                  sweep_done_q <= 1'b1;
                  cnt_q        <= `ADCSS_END_CYC - 6'h01;
                end else begin
                  state_q <= S_GAP;
                  cnt_q   <= `ADCSS_GAP_CYC - 6'h01;
                end
              end else begin
                cnt_q <= cnt_q - 6'h01;
              end
            end
          end
          S_GAP: begin
            if (phi_tick) begin
              if (cnt_q == 6'h00) begin
                state_q         <= S_CONV;
                sample_active_q <= 1'b1;
                sample_ch_q     <= next_ch;
                pi_q            <= next_pi;
                ni_q            <= next_ni;
                turn_q          <= next_turn;
                cnt_q           <= `ADCSS_CONV_CYC - 6'h01;
              end else begin
                cnt_q <= cnt_q - 6'h01;
              end
            end
          end
          S_END: begin
            if (cnt_q == 6'h00) begin
              state_q <= S_IDLE;
            end else begin
              cnt_q <= cnt_q - 6'h01;
            end
          end
          default: begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------------
  // Sample lands one cycle after the conversion ends, in the first GAP or END cycle
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_res
      localparam [2:0] IDX = g;
      always @(posedge clk) begin
        if (!reset_n) begin
          res_flat_q[g*RES_W +: RES_W] <= {RES_W{1'b0}};
        end else if (ce && res_we_q && sample_ch_q == IDX) begin
          res_flat_q[g*RES_W +: RES_W] <= smp_q;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Results are two bytes each, low byte at the even address
  assign res_hit    = (addr[ADDR_W-1:4] == RES_BASE[9:4]);
  assign rd_idx     = addr[3:1];
  assign rd_res     = res_flat_q[rd_idx*RES_W +: RES_W];
  assign rd_res_pad = {{(16-RES_W){1'b0}}, rd_res};

  // Reserved and missing bits read zero
  always @* begin
    rd_mux = 8'h00;
    if (addr == `ADCSS_ADDR_MODE) begin
      rd_mux = {clock_div_sel_0_q, conversion_start_flag_q, 1'b0, md_b_q, md_a_q, ch_sel_q};
    end else if (addr == `ADCSS_ADDR_SWEEP) begin
      rd_mux = {2'b00, analog_enable_q, clock_div_sel_1_q, 1'b0, md_x_q, scan_q};
    end else if (res_hit) begin
      rd_mux = addr[0] ? rd_res_pad[15:8] : rd_res_pad[7:0];
    end
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (!reset_n) begin
      rd_data_q <= 8'h00;
    end else if (ce) begin
      rd_data_q <= rd_stb ? rd_mux : 8'h00;
    end
  end

endmodule
`default_nettype wire

// ===== adcss_seq_asserts.sv
// Concurrent checks on the ports of the sweep sequencer, bound into its top module
`include "adcss_map.vh"
`default_nettype none

module adcss_seq_chk #(
  parameter RES_W  = 10,
  parameter ADDR_W = 10
) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0]        wr_data,
  input wire logic              wr_stb,
  input wire logic              rd_stb,
  input wire logic [7:0]        rd_data_q,
  input wire logic              clock_div_ext,
  input wire logic [RES_W-1:0]  conv_data,
  input wire logic              analog_enable_q,
  input wire logic              sample_active_q,
  input wire logic [2:0]        sample_ch_q,
  input wire logic              sweep_done_q
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [9:0] act_cnt_q;
  logic [3:0] idle_cnt_q;
  logic       mode_wr;
  logic       sweep_wr;

  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  // Decoded writes, qualified by the clock enable
  assign mode_wr  = ce && wr_stb && (addr == `ADCSS_ADDR_MODE);
  assign sweep_wr = ce && wr_stb && (addr == `ADCSS_ADDR_SWEEP);

  // Length of the running conversion and quiet time since the last one
  always @(posedge clk) begin
    if (!reset_n) begin
      act_cnt_q  <= 10'h000;
      idle_cnt_q <= 4'h0;
    end else begin
      act_cnt_q  <= sample_active_q ? act_cnt_q + 10'h001 : 10'h000;
      idle_cnt_q <= (sample_active_q || sweep_done_q) ? 4'h0 :
                    ((idle_cnt_q == 4'hF) ? idle_cnt_q : idle_cnt_q + 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_rd_idle;
    !$past(rd_stb) |-> rd_data_q == 8'h00;
  endproperty
  property p_rd_rsv;
    rd_stb && addr == `ADCSS_ADDR_SWEEP |=> rd_data_q[7:6] == 2'h0 && !rd_data_q[3];
  endproperty
  property p_en_wr;
    sweep_wr |=> analog_enable_q == $past(wr_data[`ADCSS_B_STBY]);
  endproperty
  property p_stby_off;
    !analog_enable_q |=> !sample_active_q;
  endproperty
  // A refused start must leave the converter quiet
  property p_refuse;
    mode_wr && wr_data[`ADCSS_B_START] && !analog_enable_q |=> !sample_active_q [*8];
  endproperty
  property p_start;
    mode_wr && wr_data[`ADCSS_B_START] && analog_enable_q && idle_cnt_q == 4'hF
      |=> !sample_active_q ##[1:8] sample_active_q;
  endproperty
  property p_done_pulse;
    sweep_done_q |=> !sweep_done_q;
  endproperty
  property p_done_end;
    sweep_done_q |-> $fell(sample_active_q);
  endproperty
  // Aborting writes shorten a conversion, so they are left out here
  property p_len;
    $fell(sample_active_q) && !$past(wr_stb) |-> act_cnt_q >= 10'h028 && act_cnt_q <= 10'h1E0;
  endproperty
  property p_gap;
    $fell(sample_active_q) && !sweep_done_q && !$past(wr_stb) |-> ##[1:24] sample_active_q;
  endproperty
  property p_ch_hold;
    sample_active_q && $past(sample_active_q) |-> $stable(sample_ch_q);
  endproperty

  a_rd_idle:    assert property (p_rd_idle)    else $error("read data outside read slot");
  a_rd_rsv:     assert property (p_rd_rsv)     else $error("reserved sweep bits read 1");
  a_en_wr:      assert property (p_en_wr)      else $error("standby bit not written");
  a_stby_off:   assert property (p_stby_off)   else $error("converting in standby");
  a_refuse:     assert property (p_refuse)     else $error("start taken in standby");
  a_start:      assert property (p_start)      else $error("start dummy time wrong");
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
  a_done_end:   assert property (p_done_end)   else $error("done not at conversion end");
  a_len:        assert property (p_len)        else $error("conversion length wrong");
  a_gap:        assert property (p_gap)        else $error("no next conversion after gap");
  a_ch_hold:    assert property (p_ch_hold)    else $error("input changed in conversion");

  c_done:    cover property (sweep_done_q);
  c_gap:     cover property ($fell(sample_active_q) && !sweep_done_q ##[1:24] sample_active_q);
  c_refused: cover property (mode_wr && wr_data[`ADCSS_B_START] && !analog_enable_q);

endmodule

bind adcss_seq adcss_seq_chk #(.RES_W(RES_W), .ADDR_W(ADDR_W)) i_adcss_seq_chk (
  .clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr), .wr_data(wr_data),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_q(rd_data_q), .clock_div_ext(clock_div_ext),
  .conv_data(conv_data), .analog_enable_q(analog_enable_q),
  .sample_active_q(sample_active_q), .sample_ch_q(sample_ch_q), .sweep_done_q(sweep_done_q)
);

`default_nettype wire

// ===== adcss_seq_tb.sv
// Self-checking bench for the sweep sequencer
`include "adcss_map.vh"
`default_nettype none

module adcss_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, reset_n, ce, wr_stb, rd_stb, clock_div_ext;
  logic [9:0] addr, conv_data;
  logic [7:0] wr_data, rd_data_q;
  logic       analog_enable_q, sample_active_q, sweep_done_q;
  logic [2:0] sample_ch_q;
  logic [9:0] val_tbl [8];
  logic [7:0] rd_exp [$];
  logic [2:0] ch_exp [$];
  int         bad_count, checks_done, done_cnt, act_len, d0, p, n;
  logic       rd_seen, act_prev, len_chk;

  adcss_seq i_adcss_seq (
    .clk(clk), .reset_n(reset_n), .ce(ce), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_q(rd_data_q), .clock_div_ext(clock_div_ext),
    .conv_data(conv_data), .analog_enable_q(analog_enable_q),
    .sample_active_q(sample_active_q), .sample_ch_q(sample_ch_q), .sweep_done_q(sweep_done_q)
  );

  // ----------------------------------------------------------------
  // Clock, analog core stand-in, watchdog
  // ----------------------------------------------------------------
  always #12.5 clk = ~clk;

  // Per-input value, so a result landing in the wrong register shows
  always @(posedge clk) conv_data <= val_tbl[sample_ch_q];

  // Whole run is about 4500 cycles; this leaves ample slack
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_stb  <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk);
    wr_stb  <= 1'b0;
  endtask

  // The expected value is noted here and compared by the monitor
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr   <= a;
    rd_exp.push_back(e);
    @(posedge clk);
    rd_stb <= 1'b0;
  endtask

  task automatic chk_res(input int c);
    rd(`ADCSS_ADDR_RES_BASE + 10'(2 * c), val_tbl[c][7:0]);
    rd(`ADCSS_ADDR_RES_BASE + 10'(2 * c + 1), {6'h00, val_tbl[c][9:8]});
  endtask

  task automatic new_vals();
    for (int i = 0; i < 8; i++) val_tbl[i] = 10'($urandom());
  endtask

  // Bounded wait for completion; sw=1 waits for the done pulse
  task automatic wait_for(input bit sw);
    int k;
    k = 0;
    while ((sw ? sweep_done_q !== 1'b1 : ch_exp.size() != 0) && k < 4000) begin
      @(negedge clk);
      k++;
    end
    if (k == 4000) bad_count++;
    if (sw) repeat (20) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Monitor: reads, input order, conversion length, done pulses
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (rd_seen) check(rd_data_q, rd_exp.pop_front());
    rd_seen = rd_stb;
    if (sweep_done_q === 1'b1) done_cnt++;
    if (sample_active_q === 1'b1) begin
      if (!act_prev) begin
        act_len = 0;
        check({5'h00, sample_ch_q}, ch_exp.size() ? {5'h00, ch_exp.pop_front()} : 8'hFF);
      end
      act_len++;
    end else if (act_prev && len_chk) begin
      check(8'(act_len), 8'h28);
    end
    act_prev = (sample_active_q === 1'b1);
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    ce = 1'b1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 10'h000;
    wr_data = 8'h00;
    clock_div_ext = 1'b0;
    conv_data = 10'h000;
    rd_seen = 1'b0;
    act_prev = 1'b0;
    len_chk = 1'b1;
    bad_count = 0;
    checks_done = 0;
    done_cnt = 0;
    void'($urandom(32'h788620ED));
    new_vals();
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(`ADCSS_ADDR_MODE, 8'h00);
    rd(`ADCSS_ADDR_SWEEP, 8'h00);
    rd(10'h3E0, 8'h00);
    // Start while in standby is ignored
    wr(`ADCSS_ADDR_MODE, 8'h40);
    repeat (10) @(posedge clk);
    rd(`ADCSS_ADDR_MODE, 8'h00);
    // Reserved and missing bits read as zero
    // Software keeps them 0 itself, so only the live bits are set here
    wr(`ADCSS_ADDR_SWEEP, 8'h13);
    rd(`ADCSS_ADDR_SWEEP, 8'h13);
    wr(`ADCSS_ADDR_MODE, 8'h8F);
    rd(`ADCSS_ADDR_MODE, 8'h8F);
    // One-shot on every input, undivided clock
    wr(`ADCSS_ADDR_SWEEP, 8'h20);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      ch_exp.push_back(3'(i));
      wr(`ADCSS_ADDR_MODE, 8'h40 | 8'(i));
      wait_for(1'b1);
      rd(`ADCSS_ADDR_MODE, 8'(i));
      chk_res(i);
    end
    check(8'(done_cnt), 8'h08);
    // Single sweep over every group size
    for (int g = 0; g < 4; g++) begin
      new_vals();
      wr(`ADCSS_ADDR_SWEEP, 8'h20 | 8'(g));
      for (int i = 0; i < 2 * g + 2; i++) ch_exp.push_back(3'(i));
      d0 = done_cnt;
      wr(`ADCSS_ADDR_MODE, 8'h50);
      wait_for(1'b1);
      check(8'(done_cnt - d0), 8'h01);
      rd(`ADCSS_ADDR_MODE, 8'h10);
      for (int i = 0; i < 2 * g + 2; i++) chk_res(i);
    end
    // Repeat sweep 0, channel bits set, stopped by software
    d0 = done_cnt;
    wr(`ADCSS_ADDR_SWEEP, 8'h21);
    for (int i = 0; i < 10; i++) ch_exp.push_back(3'(i % 4));
    wr(`ADCSS_ADDR_MODE, 8'h5F);
    wait_for(1'b0);
    len_chk = 1'b0;
    wr(`ADCSS_ADDR_MODE, 8'h1F);
    repeat (20) @(posedge clk);
    len_chk = 1'b1;
    rd(`ADCSS_ADDR_MODE, 8'h1F);
    // Repeat sweep 1 with one to four priority inputs
    for (int g = 0; g < 4; g++) begin
      p = g + 1;
      n = p;
      for (int i = 0; i < 6; i++) begin
        ch_exp.push_back(3'(i % p));
        ch_exp.push_back(3'(n));
        n = (n == 7) ? p : n + 1;
      end
      wr(`ADCSS_ADDR_SWEEP, 8'h24 | 8'(g));
      wr(`ADCSS_ADDR_MODE, 8'h58);
      wait_for(1'b0);
      len_chk = 1'b0;
      wr(`ADCSS_ADDR_MODE, 8'h18);
      repeat (20) @(posedge clk);
      len_chk = 1'b1;
    end
    check(8'(done_cnt - d0), 8'h00);
    // Slowest divider: flag stays 0 during the long start dummy time
    clock_div_ext <= 1'b1;
    wr(`ADCSS_ADDR_SWEEP, 8'h30);
    repeat (4) @(posedge clk);
    ch_exp.push_back(3'h6);
    len_chk = 1'b0;
    wr(`ADCSS_ADDR_MODE, 8'hC6);
    rd(`ADCSS_ADDR_MODE, 8'h86);
    repeat (10) @(posedge clk);
    rd(`ADCSS_ADDR_MODE, 8'hC6);
    wait_for(1'b1);
    rd(`ADCSS_ADDR_MODE, 8'h86);
    chk_res(6);
    // Back to standby, only once the last conversion is over
    wr(`ADCSS_ADDR_SWEEP, 8'h00);
    rd(`ADCSS_ADDR_SWEEP, 8'h00);
    // Clock enable low freezes the block, so this write is not taken
    ce <= 1'b0;
    wr(`ADCSS_ADDR_SWEEP, 8'h20);
    ce <= 1'b1;
    rd(`ADCSS_ADDR_SWEEP, 8'h00);
    repeat (4) @(posedge clk);
    print_verdict();
  end

endmodule

`default_nettype wire
